// ---- design/sync_burst_sram_cycle_decode.sv ----
/*
  Cycle decoder and storage of a synchronous flow-through burst SRAM
  with common data I/O: read, dummy read, write, write abort, deselect,
  stall and sleep, with a four-step linear or interleaved burst counter.
  Assumes the master drives the control pins, address and write data
  from logic on ref_clk_in; only the sleep request is asynchronous.
  The data pin is split into input, output and output enable.
*/
`default_nettype none

module sync_burst_sram_cycle_decode #(
  parameter int unsigned ADDR_W = 17
) (
  input  wire logic                              ref_clk_in,
  input  wire logic                              sys_rst_in,
  input  wire sram_cycle_pkg::ctrl_t             ctrl_in,
  input  wire logic [ADDR_W-1:0]                 addr_in,
  input  wire logic                              burst_order_in,
  input  wire logic                              out_en_n_in,
  input  wire logic                              sleep_request_in,
  input  wire logic [sram_cycle_pkg::DATA_W-1:0] data_io_in,
  output logic      [sram_cycle_pkg::DATA_W-1:0] data_io_out,
  output logic                                   data_io_oe_out,
  output var sram_cycle_pkg::op_state_t          op_state_out,
  output logic                                   sleep_active_out
);

  localparam int unsigned DEPTH = 1 << ADDR_W;

  // Burst position: interleaved is xor, linear is add, both wrap at four
  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] step,
    input logic       interleave
  );
    logic [1:0] sum;
    sum = 2'(start + step);
    return interleave ? (start ^ step) : sum;
  endfunction

  function automatic logic is_op_state(
    input sram_cycle_pkg::op_state_t st
  );
    return (st == sram_cycle_pkg::ST_DESELECT) ||
           (st == sram_cycle_pkg::ST_READ) ||
           (st == sram_cycle_pkg::ST_WRITE);
  endfunction

  logic [sram_cycle_pkg::DATA_W-1:0] mem_reg [DEPTH];

  sram_cycle_pkg::op_state_t state_reg;
  sram_cycle_pkg::op_state_t state_next;

  logic                 sleep_s1_reg;
  logic                 sleep_s2_reg;
  logic                 sleep_s3_reg;
  logic                 sleep_level_reg;
  logic [1:0]           sleep_cnt_reg;
  logic [ADDR_W-1:0]    base_reg;
  logic [1:0]           step_reg;
  logic                 wr_pend_reg;
  logic [ADDR_W-1:0]    wr_addr_reg;
  logic [1:0]           wr_bw_reg;
  logic                 rd_live_reg;
  logic                 rd_live_next;
  logic [sram_cycle_pkg::DATA_W-1:0] read_word;

  logic              stall;
  logic              load;
  logic              selected;
  logic              bw_any;
  logic              active;
  logic              take_load;
  logic              take_adv;
  logic              new_read;
  logic              new_write;
  logic              wr_now;
  logic [1:0]        step_up;
  logic [ADDR_W-1:0] adv_addr;
  logic [ADDR_W-1:0] op_addr;

  // Sleep request is asynchronous: three stages, counted when last two agree
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sleep_s1_reg    <= 1'b0;
      sleep_s2_reg    <= 1'b0;
      sleep_s3_reg    <= 1'b0;
      sleep_level_reg <= 1'b0;
    end else begin
      sleep_s1_reg <= sleep_request_in;
      sleep_s2_reg <= sleep_s1_reg;
      sleep_s3_reg <= sleep_s2_reg;
      if (sleep_s2_reg == sleep_s3_reg) begin
        sleep_level_reg <= sleep_s3_reg;
      end
    end
  end

  assign stall    = ctrl_in.clock_qualify_n;
  assign load     = !ctrl_in.advance_or_load;
  assign selected = !ctrl_in.chip_sel_first_n &&
                    ctrl_in.chip_sel_second_hi &&
                    !ctrl_in.chip_sel_third_n;
  assign bw_any   = ctrl_in.byte_write_sel_n != sram_cycle_pkg::BW_NONE;

  // Sleep overrides every other input, including the stall qualifier
  assign active    = is_op_state(state_reg) && !sleep_level_reg;
  assign take_load = active && !stall && load && selected;
  // Advance ignores selects and write enable; no advance while deselected
  assign take_adv  = active && !stall && !load &&
                     (state_reg != sram_cycle_pkg::ST_DESELECT);

  assign new_read  = (take_load && ctrl_in.write_en_n) ||
                     (take_adv &&
                      (state_reg == sram_cycle_pkg::ST_READ));
  // A write with no byte selected leaves nothing pending
  assign new_write = bw_any &&
                     ((take_load && !ctrl_in.write_en_n) ||
                      (take_adv &&
                       (state_reg == sram_cycle_pkg::ST_WRITE)));
  // Pending write completes at the next edge that is not stalled
  assign wr_now    = wr_pend_reg && active && !stall;

  assign step_up  = 2'(step_reg + sram_cycle_pkg::BURST_STEP);
  assign adv_addr = {base_reg[ADDR_W-1:sram_cycle_pkg::BURST_W],
                     burst_low(base_reg[sram_cycle_pkg::BURST_W-1:0],
                               step_up, burst_order_in)};
  assign op_addr  = take_load ? addr_in : adv_addr;

  // Operating state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sram_cycle_pkg::ST_DESELECT,
      sram_cycle_pkg::ST_READ,
      sram_cycle_pkg::ST_WRITE: begin
        if (sleep_level_reg) begin
          state_next = sram_cycle_pkg::ST_SLEEP_ENTRY;
        end else if (!stall && load) begin
          if (!selected) begin
            state_next = sram_cycle_pkg::ST_DESELECT;
          end else if (ctrl_in.write_en_n) begin
            state_next = sram_cycle_pkg::ST_READ;
          end else begin
            state_next = sram_cycle_pkg::ST_WRITE;
          end
        end
      end
      sram_cycle_pkg::ST_SLEEP_ENTRY: begin
        if (sleep_cnt_reg ==
            2'(sram_cycle_pkg::SLEEP_ENTRY_CYCLES - 2'h1)) begin
          state_next = sram_cycle_pkg::ST_SLEEP;
        end
      end
      sram_cycle_pkg::ST_SLEEP: begin
        if (!sleep_level_reg) begin
          state_next = sram_cycle_pkg::ST_SLEEP_EXIT;
        end
      end
      sram_cycle_pkg::ST_SLEEP_EXIT: begin
        if (sleep_level_reg) begin
          state_next = sram_cycle_pkg::ST_SLEEP;
        end else if (sleep_cnt_reg ==
                     2'(sram_cycle_pkg::SLEEP_EXIT_CYCLES - 2'h1)) begin
          state_next = sram_cycle_pkg::ST_DESELECT;
        end
      end
      default: begin
        state_next = sram_cycle_pkg::ST_DESELECT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= sram_cycle_pkg::ST_DESELECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sleep entry and exit cycle count
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || (state_next != state_reg)) begin
      sleep_cnt_reg <= sram_cycle_pkg::SLEEP_CNT_RESET;
    end else if ((state_reg == sram_cycle_pkg::ST_SLEEP_ENTRY) ||
                 (state_reg == sram_cycle_pkg::ST_SLEEP_EXIT)) begin
      sleep_cnt_reg <= 2'(sleep_cnt_reg + 2'h1);
    end
  end

  // Burst address: start on load, step on advance, hold on stall
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      base_reg <= '0;
      step_reg <= sram_cycle_pkg::BURST_FIRST;
    end else if (take_load) begin
      base_reg <= addr_in;
      step_reg <= sram_cycle_pkg::BURST_FIRST;
    end else if (take_adv) begin
      step_reg <= step_up;
    end
  end

  // Write pending from address edge to data edge; dropped by sleep
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !active) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_bw_reg   <= sram_cycle_pkg::BW_NONE;
    end else if (!stall) begin
      wr_pend_reg <= new_write;
      wr_addr_reg <= op_addr;
      wr_bw_reg   <= ctrl_in.byte_write_sel_n;
    end
  end

  // Lane writes: a lane whose select is high keeps its old contents
  always_ff @(posedge ref_clk_in) begin
    if (wr_now) begin
      for (int lane = 0; lane < sram_cycle_pkg::LANE_COUNT; lane++) begin
        if (!wr_bw_reg[lane]) begin
          mem_reg[wr_addr_reg][lane*sram_cycle_pkg::LANE_W +:
                               sram_cycle_pkg::LANE_W] <=
            data_io_in[lane*sram_cycle_pkg::LANE_W +:
                       sram_cycle_pkg::LANE_W];
        end
      end
    end
  end

  // Flow-through read word, forwarding a write completing at this edge
  always_comb begin
    read_word = mem_reg[op_addr];
    if (wr_now && (wr_addr_reg == op_addr)) begin
      for (int lane = 0; lane < sram_cycle_pkg::LANE_COUNT; lane++) begin
        if (!wr_bw_reg[lane]) begin
          read_word[lane*sram_cycle_pkg::LANE_W +: sram_cycle_pkg::LANE_W] =
            data_io_in[lane*sram_cycle_pkg::LANE_W +:
                       sram_cycle_pkg::LANE_W];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_io_out <= sram_cycle_pkg::DATA_RESET;
    end else if (new_read) begin
      data_io_out <= read_word;
    end
  end

  // Read data is live from a read edge until a non-read, unstalled edge
  always_comb begin
    rd_live_next = rd_live_reg;
    if (!active) begin
      rd_live_next = 1'b0;
    end else if (!stall) begin
      rd_live_next = new_read;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_live_reg <= 1'b0;
    end else begin
      rd_live_reg <= rd_live_next;
    end
  end

  // Drivers follow output enable, never during writes, sleep or deselect
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_io_oe_out <= 1'b0;
    end else begin
      data_io_oe_out <= rd_live_next && !out_en_n_in;
    end
  end

  assign op_state_out = state_reg;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sleep_active_out <= 1'b0;
    end else begin
      sleep_active_out <= !is_op_state(state_next);
    end
  end

endmodule

`default_nettype wire

// ---- design/sram_cycle_pkg.sv ----
/*
  Shared constants and types for the burst SRAM cycle decoder: data word
  layout, byte lane layout, burst counter width, sleep timing counts,
  the control pin bundle and the operating state enumeration.
  Assumes it is compiled before every file that names it.
*/
`default_nettype none

package sram_cycle_pkg;

  // Data word: two lanes of eight data bits plus one parity bit each
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned LANE_COUNT = 2;
  localparam int unsigned LANE_W     = 9;

  // Burst counter steps the two lowest address bits
  localparam int unsigned BURST_W    = 2;
  localparam logic [1:0]  BURST_FIRST = 2'h0;
  localparam logic [1:0]  BURST_STEP  = 2'h1;

  // Byte write selects: all high means no byte is written
  localparam logic [1:0]  BW_NONE    = 2'h3;

  // Sleep entry and exit each take this many clock cycles
  localparam logic [1:0]  SLEEP_ENTRY_CYCLES = 2'h2;
  localparam logic [1:0]  SLEEP_EXIT_CYCLES  = 2'h2;
  localparam logic [1:0]  SLEEP_CNT_RESET    = 2'h0;

  localparam logic [DATA_W-1:0] DATA_RESET = 18'h0_0000;

  // Synchronous control pins sampled at each rising edge
  typedef struct packed {
    logic       chip_sel_first_n;
    logic       chip_sel_second_hi;
    logic       chip_sel_third_n;
    logic       advance_or_load;
    logic       write_en_n;
    logic [1:0] byte_write_sel_n;
    logic       clock_qualify_n;
  } ctrl_t;

  typedef enum logic [2:0] {
    ST_DESELECT,
    ST_READ,
    ST_WRITE,
    ST_SLEEP_ENTRY,
    ST_SLEEP,
    ST_SLEEP_EXIT
  } op_state_t;

endpackage

`default_nettype wire

// ---- tb/sram_decode_asserts.sv ----
/*
  Checker of the burst SRAM cycle decoder: drive, float, stall, reset
  and sleep timing seen at the ports.
  Assumes it is bound to the decoder top and sees only its ports.
*/
`default_nettype none
module sram_decode_asserts (
  input wire logic                              ref_clk_in,
  input wire logic                              sys_rst_in,
  input wire sram_cycle_pkg::ctrl_t             ctrl_in,
  input wire logic                              out_en_n_in,
  input wire logic                              sleep_request_in,
  input wire logic [sram_cycle_pkg::DATA_W-1:0] data_io_out,
  input wire logic                              data_io_oe_out,
  input wire sram_cycle_pkg::op_state_t         op_state_out,
  input wire logic                              sleep_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sleep_hist_reg;
  logic       awake, run, ld, sel, st_rd, st_wr, st_ds, st_en, st_ex;
  // Recent sleep requests: edges near one are not judged as plain cycles
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sleep_hist_reg <= 4'h0;
    end else begin
      sleep_hist_reg <= {sleep_hist_reg[2:0], sleep_request_in};
    end
  end
  assign st_rd = op_state_out == sram_cycle_pkg::ST_READ;
  assign st_wr = op_state_out == sram_cycle_pkg::ST_WRITE;
  assign st_ds = op_state_out == sram_cycle_pkg::ST_DESELECT;
  assign st_en = op_state_out == sram_cycle_pkg::ST_SLEEP_ENTRY;
  assign st_ex = op_state_out == sram_cycle_pkg::ST_SLEEP_EXIT;
  assign awake = sleep_hist_reg == 4'h0 && !sleep_request_in
    && (st_rd || st_wr || st_ds);
  assign run = awake && !ctrl_in.clock_qualify_n;
  assign ld  = run && !ctrl_in.advance_or_load;
  assign sel = !ctrl_in.chip_sel_first_n && ctrl_in.chip_sel_second_hi
    && !ctrl_in.chip_sel_third_n;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_read_drive: assert property (
    ld && sel && ctrl_in.write_en_n && !out_en_n_in
    |=> data_io_oe_out && st_rd) else $error("read start not driven");
  a_burst_read: assert property (
    run && st_rd && ctrl_in.advance_or_load && !out_en_n_in
    |=> data_io_oe_out && st_rd) else $error("burst read not driven");
  a_dummy_float: assert property (
    run && out_en_n_in |=> !data_io_oe_out)
    else $error("driven with output enable off");
  a_write_mask: assert property (
    ld && sel && !ctrl_in.write_en_n || run && st_wr && ctrl_in.advance_or_load
    |=> !data_io_oe_out) else $error("driven in write cycle");
  a_deselect: assert property (
    ld && !sel |=> !data_io_oe_out && st_ds) else $error("deselect failed");
  a_stay_desel: assert property (
    run && st_ds && ctrl_in.advance_or_load |=> st_ds && !data_io_oe_out)
    else $error("left deselect on advance");
  a_stall_hold: assert property (
    awake && ctrl_in.clock_qualify_n |=> $stable(data_io_out)
    && $stable(data_io_oe_out) && $stable(op_state_out))
    else $error("stalled edge changed state");
  a_reset_idle: assert property (
    $past(sys_rst_in) |-> st_ds && !data_io_oe_out && !sleep_active_out)
    else $error("not idle after reset");
  a_sleep_float: assert property (
    sleep_active_out |-> !data_io_oe_out) else $error("driven in sleep");
  a_sleep_entry: assert property (
    $rose(st_en) |-> st_en[*2] ##1 op_state_out == sram_cycle_pkg::ST_SLEEP)
    else $error("sleep entry length wrong");
  a_sleep_exit: assert property (
    $rose(st_ex) |-> st_ex[*2] ##1 st_ds) else $error("sleep exit wrong");
endmodule
bind sync_burst_sram_cycle_decode sram_decode_asserts u_chk (
  .ref_clk_in      (ref_clk_in),
  .sys_rst_in      (sys_rst_in),
  .ctrl_in         (ctrl_in),
  .out_en_n_in     (out_en_n_in),
  .sleep_request_in(sleep_request_in),
  .data_io_out     (data_io_out),
  .data_io_oe_out  (data_io_oe_out),
  .op_state_out    (op_state_out),
  .sleep_active_out(sleep_active_out)
);
`default_nettype wire

// ---- tb/bus_master_data.sv ----
/*
  Data pin side of the bus master: resolves the common data pins from
  the device drive and the master write data.
  Assumes the bench says when the master drives.
*/
`default_nettype none
module bus_master_data (
  input  wire logic        clk_in,
  input  wire logic [17:0] dev_q_in,
  input  wire logic        dev_oe_in,
  input  wire logic        mst_drv_in,
  input  wire logic [17:0] mst_d_in,
  output logic      [17:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] last_reg = 18'h0_0000;
  always_ff @(posedge clk_in) last_reg <= bus_out;
  // Undriven pins show the inverse of the last level, never a stale match
  assign bus_out = dev_oe_in  ? dev_q_in :
                   mst_drv_in ? mst_d_in : ~last_reg;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Testbench of the burst SRAM cycle decoder: a table of bus cycles, then
  reset and sleep cases.
  Assumes the design package and a four-bit address.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    sram_cycle_pkg::ctrl_t ctl;
    logic [3:0]            adr;
    logic                  oen;
    logic                  ord;
    logic                  drv;
    logic [17:0]           wd;
    logic                  eoe;
    logic                  chk;
    logic [17:0]           eq;
  } row_t;
  localparam sram_cycle_pkg::ctrl_t RD = 8'h48, WR = 8'h40, WL = 8'h44,
    WN = 8'h46, AV = 8'hB8, AN = 8'hBE, DS = 8'hC8, STL = 8'h49, WH = 8'h42;
  localparam logic [17:0] D0 = 18'h2_A5C3, D1 = 18'h1_5A3C,
    D2 = 18'h3_0F0F, D3 = 18'h0_F0F1, JK = 18'h3_FFFF, NO = 18'h0_0000;
  localparam logic L = 1'h0, H = 1'h1;
  // Burst writes 5..4, forwarded and burst reads, aborts, lane write
  localparam row_t ROWS [22] = '{
    '{WR, 4'h5, L, L, L, NO, L, L, NO}, '{AV, 4'h0, L, L, H, D0, L, L, NO},
    '{AV, 4'h0, L, L, H, D1, L, L, NO}, '{AV, 4'h0, L, L, H, D2, L, L, NO},
    '{RD, 4'h4, L, L, H, D3, H, H, D3}, '{AV, 4'h0, L, H, L, NO, H, H, D0},
    '{STL, 4'h0, L, L, L, NO, H, H, D0}, '{AV, 4'h0, L, L, L, NO, H, H, D1},
    '{AV, 4'h0, H, L, L, NO, L, L, NO}, '{AV, 4'h0, L, L, L, NO, H, H, D3},
    '{DS, 4'h0, L, L, L, NO, L, L, NO}, '{AV, 4'h0, L, L, L, NO, L, L, NO},
    '{RD, 4'h6, H, L, L, NO, L, L, NO}, '{AV, 4'h0, L, L, L, NO, H, H, D2},
    '{WN, 4'h6, L, L, L, NO, L, L, NO}, '{AN, 4'h0, L, L, H, JK, L, L, NO},
    '{WL, 4'h5, L, L, H, JK, L, L, NO}, '{RD, 4'h6, L, L, H, JK, H, H, D1},
    '{RD, 4'h7, L, L, L, NO, H, H, D2},
    '{RD, 4'h5, L, L, L, NO, H, H, 18'h2_A5FF},
    '{8'h08, 4'h0, L, L, L, NO, L, L, NO}, '{8'h68, 4'h0, L, L, L, NO, L, L, NO}
  };
  logic                      clk = 1'h0;
  logic                      rst = 1'h1;
  sram_cycle_pkg::ctrl_t     ctl = DS;
  logic [3:0]                adr = 4'h0;
  logic                      oen = 1'h1, ord = 1'h0, drv = 1'h0;
  logic                      sleep_req = 1'h0;
  logic [17:0]               wd = 18'h0_0000, bus, q;
  logic                      oe, slp;
  sram_cycle_pkg::op_state_t st;
  int                        err_count = 0, checks_done = 0;
  always #5 clk = ~clk;
  sync_burst_sram_cycle_decode #(.ADDR_W(4)) u_dut (
    .ref_clk_in      (clk),
    .sys_rst_in      (rst),
    .ctrl_in         (ctl),
    .addr_in         (adr),
    .burst_order_in  (ord),
    .out_en_n_in     (oen),
    .sleep_request_in(sleep_req),
    .data_io_in      (bus),
    .data_io_out     (q),
    .data_io_oe_out  (oe),
    .op_state_out    (st),
    .sleep_active_out(slp)
  );
  bus_master_data u_bus (
    .clk_in    (clk),
    .dev_q_in  (q),
    .dev_oe_in (oe),
    .mst_drv_in(drv),
    .mst_d_in  (wd),
    .bus_out   (bus)
  );
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    row_t r;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i <= 22; i++) begin
      @(negedge clk);
      if (i > 0) begin
        r = ROWS[i-1];
        chk(18'(oe), 18'(r.eoe));
        if (r.chk) begin
          chk(q, r.eq);
        end
      end
      if (i < 22) begin
        r = ROWS[i];
        {ctl, adr, oen, ord, drv, wd} =
          {r.ctl, r.adr, r.oen, r.ord, r.drv, r.wd};
      end
    end
    {ctl, adr, oen} = {RD, 4'h4, 1'h0};
    @(negedge clk);
    chk(q, D3);
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    chk(18'(oe), NO);
    chk(18'(st), 18'(sram_cycle_pkg::ST_DESELECT));
    ctl = DS;
    @(negedge clk);
    sleep_req = 1'h1;
    for (int n = 0; n < 8 && slp !== 1'h1; n++) @(negedge clk);
    chk(18'(slp), 18'h0_0001);
    ctl = RD;
    repeat (3) @(negedge clk);
    chk(18'(oe), NO);
    ctl = DS;
    sleep_req = 1'h0;
    for (int n = 0; n < 12 && slp !== 1'h0; n++) @(negedge clk);
    chk(18'(st), 18'(sram_cycle_pkg::ST_DESELECT));
    {ctl, adr} = {RD, 4'h5};
    @(negedge clk);
    chk(q, 18'h2_A5FF);
    // Upper lane only write, forwarded into a read of the same word
    {ctl, adr} = {WH, 4'h5};
    @(negedge clk);
    {ctl, drv, wd} = {RD, 1'h1, D1};
    @(negedge clk);
    drv = 1'h0;
    chk(q, 18'h1_5BFF);
    tally_and_finish();
  end
  // The whole sequence needs under 80 cycles
  initial begin
    repeat (300) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
